// ==== rtl/serial_port_pkg.sv ====
// Package: constants, register map and state types of the clocked serial port
package serial_port_pkg;

  // ==========================================================================
  // Register map (byte addresses on the Avalon-MM slave)
  // ==========================================================================
  localparam logic [15:0] MODE_OFFSET = 16'hFF80;
  localparam logic [15:0] SHIFT_OFFSET = 16'hFF88;
  localparam logic [15:0] STATUS_OFFSET = 16'hFF8C;

  // ==========================================================================
  // Mode register fields
  // ==========================================================================
  localparam int TRANSMIT_ENABLE_BIT = 7;
  localparam int RECEIVE_ENABLE_BIT = 6;
  localparam int WAKE_ON_ADDRESS_BIT = 5;
  localparam int DATA_PIN_SELECT_BIT = 4;
  localparam int OPERATING_MODE_HI_BIT = 3;
  localparam int OPERATING_MODE_LO_BIT = 2;
  localparam int CLOCK_SELECT_HI_BIT = 1;
  localparam int CLOCK_SELECT_LO_BIT = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;

  // Operating mode codes
  localparam logic [1:0] MODE_THREE_WIRE_MSB = 2'h0;
  localparam logic [1:0] MODE_THREE_WIRE_LSB = 2'h1;
  localparam logic [1:0] MODE_TWO_WIRE_BUS = 2'h2;

  // Clock select codes
  localparam logic [1:0] CLOCK_EXTERNAL = 2'h0;
  localparam logic [1:0] CLOCK_BAUD_HALF = 2'h1;
  localparam logic [1:0] CLOCK_SLOW = 2'h2;
  localparam logic [1:0] CLOCK_FAST = 2'h3;

  // ==========================================================================
  // Timing: system clock division ratios and serial frame length
  // ==========================================================================
  localparam int SLOW_DIVIDE = 32;
  localparam int FAST_DIVIDE = 8;
  localparam logic [4:0] SLOW_HALF = 5'(SLOW_DIVIDE / 2 - 1);
  localparam logic [4:0] FAST_HALF = 5'(FAST_DIVIDE / 2 - 1);
  localparam logic [3:0] FRAME_LAST_BIT = 4'h7;

  // ==========================================================================
  // Pin drive carrier and whole block state
  // ==========================================================================
  typedef struct packed {
    logic sck_out;
    logic sck_oe_n;
    logic a_out;
    logic a_oe_n;
    logic b_out;
    logic b_oe_n;
  } pin_drive_type;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] shifter;
    logic [3:0] bit_count;
    logic busy;
    logic [4:0] half_count;
    logic sck_level;
    logic so_level;
    logic [1:0] sck_sync;
    logic sck_prev;
    logic [1:0] a_sync;
    logic [1:0] b_sync;
    logic waitrequest;
    logic [31:0] readdata;
    logic irq;
    pin_drive_type pins;
  } state_type;

  localparam pin_drive_type PINS_RESET = '{
    sck_out: 1'b1, sck_oe_n: 1'b1, a_out: 1'b1, a_oe_n: 1'b1, b_out: 1'b1, b_oe_n: 1'b1};

  localparam state_type STATE_RESET = '{
    mode: MODE_RESET, shifter: 8'h00, bit_count: 4'h0, busy: 1'b0, half_count: 5'h00,
    sck_level: 1'b1, so_level: 1'b1, sck_sync: 2'h3, sck_prev: 1'b1, a_sync: 2'h3,
    b_sync: 2'h3, waitrequest: 1'b1, readdata: 32'h0000_0000, irq: 1'b0, pins: PINS_RESET};

endpackage

// ==== rtl/serial_port.sv ====
// Clocked serial port: mode register, three-wire shift engine, two-wire data pin drive
`timescale 1ns/1ps

// How it works
// - Each transfer moves one eight-bit frame
// - Mode field picks MSB, LSB or bus mode
// - Output next bit on serial clock fall
// - Sample input bit on serial clock rise
// - Interrupt on eighth rising clock edge
// - Internal clock stops high after eighth rise
// - Clock select: external, baud half, /32, /8
// - Bus mode uses line A or B
// - Pin select ignored in three-wire mode
// - Wake off: interrupt after every transfer
// - Wake on: address-only interrupt, output floats
// - Receive disabled shifts in zeros
// - Transmit disabled floats both data pins
// - Internal clock drives pulses once started
// - External clock edges ignored before start
// - Mode register resets to zero, read/write
// - Bus data pin is open drain
// - Receive starts on enable rise or read
// - No enable-rise start on re-set or with transmit on
// - Both enables off clears clock counter
module serial_port #(
  parameter logic [7:0] OWN_ADDRESS = 8'hA5
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // Avalon-MM register slave
  input wire logic [15:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // Baud generator tick from same-clock logic
  input wire logic BAUD_TICK,
  // Serial clock pin
  input wire logic SCK_IN,
  output logic SCK_OUT,
  output logic SCK_OE_N,
  // Data line A (serial out / bus line A)
  input wire logic DATA_A_IN,
  output logic DATA_A_OUT,
  output logic DATA_A_OE_N,
  // Data line B (serial in / bus line B)
  input wire logic DATA_B_IN,
  output logic DATA_B_OUT,
  output logic DATA_B_OE_N,
  // Transfer complete
  output logic TRANSFER_DONE_IRQ
);
  import serial_port_pkg::*;

  state_type cur;
  state_type next;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Bit that leaves the shift register first for the chosen order
  function automatic logic leaving_bit(input logic [7:0] value, input logic lsb_first);
    leaving_bit = lsb_first ? value[0] : value[7];
  endfunction

  // Shift register after one bit enters at the end opposite the leaving one
  function automatic logic [7:0] shift_in(input logic [7:0] value, input logic lsb_first,
                                          input logic bit_in);
    shift_in = lsb_first ? {bit_in, value[7:1]} : {value[6:0], bit_in};
  endfunction

  // ==========================================================================
  // Mode decode
  // ==========================================================================
  logic transmit_enable;
  logic receive_enable;
  logic wake_on_address;
  logic data_pin_select;
  logic [1:0] operating_mode;
  logic [1:0] clock_select;
  logic two_wire_bus_mode;
  logic lsb_first;
  logic internal_clock;

  assign transmit_enable = cur.mode[TRANSMIT_ENABLE_BIT];
  assign receive_enable = cur.mode[RECEIVE_ENABLE_BIT];
  assign wake_on_address = cur.mode[WAKE_ON_ADDRESS_BIT];
  assign data_pin_select = cur.mode[DATA_PIN_SELECT_BIT];
  assign operating_mode = cur.mode[OPERATING_MODE_HI_BIT:OPERATING_MODE_LO_BIT];
  assign clock_select = cur.mode[CLOCK_SELECT_HI_BIT:CLOCK_SELECT_LO_BIT];
  // Prohibited code 11 falls back to three-wire MSB first
  assign two_wire_bus_mode = (operating_mode == MODE_TWO_WIRE_BUS);
  assign lsb_first = (operating_mode == MODE_THREE_WIRE_LSB);
  assign internal_clock = (clock_select != CLOCK_EXTERNAL);

  // ==========================================================================
  // Next state
  // ==========================================================================
  logic sck_fall;
  logic sck_rise;
  logic half_tick;
  logic start;
  logic access;
  logic serial_in;
  logic [7:0] new_mode;
  logic hold_outputs_off;

  // One process computes the whole next state from the registered state
  always_comb begin
    next = cur;
    sck_fall = 1'b0;
    sck_rise = 1'b0;
    half_tick = 1'b0;
    start = 1'b0;
    serial_in = 1'b0;
    new_mode = cur.mode;
    hold_outputs_off = 1'b0;
    access = (READ || WRITE) && !cur.waitrequest;

    // Pin synchronisers; only the second stage is looked at
    next.sck_sync = {cur.sck_sync[0], SCK_IN};
    next.sck_prev = cur.sck_sync[1];
    next.a_sync = {cur.a_sync[0], DATA_A_IN};
    next.b_sync = {cur.b_sync[0], DATA_B_IN};
    next.irq = 1'b0;

    // Serial clock source: internal divider/baud, or synchronised pin edges
    if (internal_clock) begin
      if (cur.busy) begin
        if (clock_select == CLOCK_BAUD_HALF) begin
          half_tick = BAUD_TICK;
        end else begin
          half_tick = (cur.half_count == ((clock_select == CLOCK_SLOW) ? SLOW_HALF
                                                                       : FAST_HALF));
          next.half_count = half_tick ? 5'h00 : cur.half_count + 5'h01;
        end
        if (half_tick) begin
          next.sck_level = !cur.sck_level;
          sck_fall = cur.sck_level;
          sck_rise = !cur.sck_level;
        end
      end
    end else begin
      // Edges before a start are dropped so the output holds its level
      sck_fall = cur.busy && cur.sck_prev && !cur.sck_sync[1];
      sck_rise = cur.busy && !cur.sck_prev && cur.sck_sync[1];
    end

    // Input bit: pin of the mode, or zero while reception is off
    if (two_wire_bus_mode) begin
      serial_in = data_pin_select ? cur.b_sync[1] : cur.a_sync[1];
    end else begin
      serial_in = cur.b_sync[1];
    end
    serial_in = serial_in && receive_enable;

    // Shift engine: out on fall, in on rise, same register both ways
    if (sck_fall) begin
      next.so_level = leaving_bit(cur.shifter, lsb_first);
    end
    if (sck_rise) begin
      next.shifter = shift_in(cur.shifter, lsb_first, serial_in);
      next.bit_count = cur.bit_count + 4'h1;
      if (cur.bit_count == FRAME_LAST_BIT) begin
        // Eighth rise ends the frame; internal clock rests high
        next.busy = 1'b0;
        next.bit_count = 4'h0;
        next.sck_level = 1'b1;
        if (wake_on_address) begin
          next.irq = two_wire_bus_mode
                     && (shift_in(cur.shifter, lsb_first, serial_in) == OWN_ADDRESS);
        end else begin
          next.irq = 1'b1;
        end
      end
    end

    // Bus slave: one wait cycle, then the access completes
    next.waitrequest = 1'b1;
    if ((READ || WRITE) && cur.waitrequest) begin
      next.waitrequest = 1'b0;
      unique case (ADDRESS)
        MODE_OFFSET: next.readdata = {24'h000000, cur.mode};
        SHIFT_OFFSET: next.readdata = {24'h000000, cur.shifter};
        STATUS_OFFSET: next.readdata = {27'h0000000, cur.busy, cur.bit_count};
        default: next.readdata = 32'h0000_0000;
      endcase
    end
    if (access && WRITE && BYTEENABLE[0]) begin
      unique case (ADDRESS)
        MODE_OFFSET: begin
          new_mode = WRITEDATA[7:0];
          next.mode = new_mode;
          // Only a 0 to 1 step with transmit off starts reception
          start = !cur.mode[RECEIVE_ENABLE_BIT] && new_mode[RECEIVE_ENABLE_BIT]
                  && !new_mode[TRANSMIT_ENABLE_BIT];
        end
        SHIFT_OFFSET: begin
          next.shifter = WRITEDATA[7:0];
          start = transmit_enable;
        end
        default: begin
        end
      endcase
    end
    if (access && READ && (ADDRESS == SHIFT_OFFSET) && receive_enable) begin
      start = 1'b1;
    end

    // A start restarts the frame from bit one
    if (start) begin
      next.busy = 1'b1;
      next.bit_count = 4'h0;
      next.half_count = 5'h00;
      next.sck_level = 1'b1;
    end

    // Both enables off re-aligns the counter to a fresh frame
    if (!new_mode[TRANSMIT_ENABLE_BIT] && !new_mode[RECEIVE_ENABLE_BIT]) begin
      next.busy = 1'b0;
      next.bit_count = 4'h0;
      next.sck_level = 1'b1;
    end

    // Clock pin: driven only for internal sources, idles high
    next.pins.sck_oe_n = !internal_clock;
    next.pins.sck_out = next.sck_level;

    // Data pins; registered from the next-state level so the pins move in the same cycle as the engine
    hold_outputs_off = !transmit_enable || wake_on_address;
    next.pins.a_out = 1'b0;
    next.pins.b_out = 1'b0;
    next.pins.a_oe_n = 1'b1;
    next.pins.b_oe_n = 1'b1;
    if (two_wire_bus_mode) begin
      // Open drain: pull low for a zero, release for a one
      if (data_pin_select) begin
        next.pins.b_oe_n = hold_outputs_off || next.so_level;
      end else begin
        next.pins.a_oe_n = hold_outputs_off || next.so_level;
      end
    end else begin
      next.pins.a_out = next.so_level;
      next.pins.a_oe_n = hold_outputs_off;
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Every output below is a bit of this register
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      cur <= STATE_RESET;
    end else begin
      cur <= next;
    end
  end

  assign READDATA = cur.readdata;
  assign WAITREQUEST = cur.waitrequest;
  assign SCK_OUT = cur.pins.sck_out;
  assign SCK_OE_N = cur.pins.sck_oe_n;
  assign DATA_A_OUT = cur.pins.a_out;
  assign DATA_A_OE_N = cur.pins.a_oe_n;
  assign DATA_B_OUT = cur.pins.b_out;
  assign DATA_B_OE_N = cur.pins.b_oe_n;
  assign TRANSFER_DONE_IRQ = cur.irq;

endmodule // serial_port

// ==== testbench/serial_port_asserts.sv ====
// Checker for the clocked serial port bus answer and pin behaviour
`timescale 1ns/1ps
// ==========
// Assertions on the top module ports
module serial_port_asserts
  import serial_port_pkg::*;
(
  // Clock, reset and register bus
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [15:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [31:0] READDATA,
  input wire logic WAITREQUEST,
  // Serial pins
  input wire logic SCK_OUT,
  input wire logic SCK_OE_N,
  input wire logic DATA_A_OUT,
  input wire logic DATA_A_OE_N,
  input wire logic DATA_B_OUT,
  input wire logic DATA_B_OE_N,
  input wire logic TRANSFER_DONE_IRQ
);
  import serial_port_pkg::*;
  logic [7:0] m;
  logic [3:0] rises;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  // Shadow of the mode register and a count of driven clock rises per frame
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      m <= 8'h00;
      rises <= 4'h0;
    end else begin
      if (WRITE && !WAITREQUEST && BYTEENABLE[0] && ADDRESS == MODE_OFFSET) m <= WRITEDATA[7:0];
      // Abort clears the count too, so a restarted frame counts from one
      if (TRANSFER_DONE_IRQ || m[7:6] == 2'h0) rises <= 4'h0;
      else if (!SCK_OE_N && $rose(SCK_OUT)) rises <= rises + 4'h1;
    end
  end
  property p_wait_one; $rose(READ || WRITE) |=> !WAITREQUEST ##1 WAITREQUEST; endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer not one cycle");
  property p_mode_read; READ && !WAITREQUEST && ADDRESS == MODE_OFFSET |-> READDATA == {24'h0, m};
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode read mismatch");
  // The pulse shares its edge with the eighth rise, which the counter has not taken in yet
  property p_eight; TRANSFER_DONE_IRQ && !SCK_OE_N |-> $rose(SCK_OUT) && rises == 4'h7;
  endproperty
  a_eight: assert property (p_eight) else $error("frame not eight clocks");
  // An abort may cut a low phase short, so it ends the attempt
  property p_fast_low;
    @(posedge CLOCK) disable iff (!RESETN || m[7:6] == 2'h0)
    $fell(SCK_OUT) && m[1:0] == CLOCK_FAST |-> !SCK_OUT [*4] ##1 SCK_OUT;
  endproperty
  a_fast_low: assert property (p_fast_low) else $error("fast clock half period");
  property p_sck_drive; m[1:0] == $past(m[1:0]) |-> SCK_OE_N == (m[1:0] == CLOCK_EXTERNAL);
  endproperty
  a_sck_drive: assert property (p_sck_drive) else $error("clock pin direction");
  property p_out_fall; $changed(DATA_A_OUT) && !m[3] && !SCK_OE_N && m == $past(m) |-> $fell(SCK_OUT);
  endproperty
  a_out_fall: assert property (p_out_fall) else $error("data moved off falling edge");
  property p_tx_off; !m[7] && !$past(m[7]) |-> DATA_A_OE_N && DATA_B_OE_N; endproperty
  a_tx_off: assert property (p_tx_off) else $error("data pin driven with transmit off");
  property p_open_drain; m[3:2] == MODE_TWO_WIRE_BUS && m == $past(m)
    |-> (DATA_A_OE_N || !DATA_A_OUT) && (DATA_B_OE_N || !DATA_B_OUT); endproperty
  a_open_drain: assert property (p_open_drain) else $error("bus pin driven high");
  property p_pin_sel; m[3:2] == MODE_TWO_WIRE_BUS && m == $past(m)
    |-> (m[4] ? DATA_A_OE_N : DATA_B_OE_N); endproperty
  a_pin_sel: assert property (p_pin_sel) else $error("unused bus pin driven");
  cover property (TRANSFER_DONE_IRQ && SCK_OE_N);
  cover property (m[3:2] == MODE_TWO_WIRE_BUS && !DATA_B_OE_N);
  cover property ($fell(SCK_OUT) && m[1:0] == CLOCK_BAUD_HALF);
endmodule // serial_port_asserts

bind serial_port serial_port_asserts chk (.CLOCK, .RESETN, .ADDRESS, .READ, .WRITE, .WRITEDATA,
  .BYTEENABLE, .READDATA, .WAITREQUEST, .SCK_OUT, .SCK_OE_N, .DATA_A_OUT, .DATA_A_OE_N,
  .DATA_B_OUT, .DATA_B_OE_N, .TRANSFER_DONE_IRQ);

// ==== testbench/serial_peer.sv ====
// Peripheral model at the far end of the three-wire link
`timescale 1ns/1ps
// ==========
// Peer: MSB-first shifter clocked by the link clock
module serial_peer (
  // Link lines
  input wire logic sck,
  input wire logic din,
  output logic dout,
  // Byte to send and last eight bits heard
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  logic [2:0] n = 3'h0;
  initial dout = 1'b1;
  initial rx_byte = 8'h00;
  // Next bit on the falling edge; wraps every eight so frames stay aligned
  always @(negedge sck) begin
    dout <= tx_byte[3'h7 - n];
    n <= n + 3'h1;
  end
  // Sample on the rising edge
  always @(posedge sck) rx_byte <= {rx_byte[6:0], din};
endmodule // serial_peer

// ==== testbench/clocked_serial_three_wire_port_bench.sv ====
// Testbench for the clocked serial port with a three-wire peer
`timescale 1ns/1ps
// ==========
// Bench top
module clocked_serial_three_wire_port_bench;
  import serial_port_pkg::*;
  logic CLOCK = 1'b0, RESETN = 1'b0, READ = 1'b0, WRITE = 1'b0, BAUD_TICK = 1'b0;
  logic [15:0] ADDRESS = 16'h0000;
  logic [31:0] WRITEDATA = 32'h0, READDATA, q;
  logic [3:0] BYTEENABLE = 4'hF;
  logic WAITREQUEST, SCK_OUT, SCK_OE_N, DATA_A_OUT, DATA_A_OE_N, DATA_B_OUT, DATA_B_OE_N;
  logic TRANSFER_DONE_IRQ, peer_out, got, ext_sck = 1'b1, pulled = 1'b0;
  logic [7:0] d, p = 8'h00, peer_rx;
  int err_count = 0, samples_checked = 0, gap = 0;
  // Pin levels: a released clock reads ext_sck, released line A the pull-up, released line B the peer or, when pulled, the pull-up
  wire sck = SCK_OE_N ? ext_sck : SCK_OUT;
  wire line_a = DATA_A_OE_N ? 1'b1 : DATA_A_OUT;
  wire line_b = !DATA_B_OE_N ? DATA_B_OUT : (pulled ? 1'b1 : peer_out);
  serial_port uut (.CLOCK, .RESETN, .ADDRESS, .READ, .WRITE, .WRITEDATA, .BYTEENABLE,
    .READDATA, .WAITREQUEST, .BAUD_TICK, .SCK_IN(sck), .SCK_OUT, .SCK_OE_N,
    .DATA_A_IN(line_a), .DATA_A_OUT, .DATA_A_OE_N, .DATA_B_IN(line_b), .DATA_B_OUT,
    .DATA_B_OE_N, .TRANSFER_DONE_IRQ);
  serial_peer peer (.sck, .din(line_a), .dout(peer_out), .tx_byte(p), .rx_byte(peer_rx));
  initial forever #50 CLOCK = ~CLOCK;
  // Baud ticks at random spacing, never closer than the input synchronisers need
  always @(posedge CLOCK) begin
    gap <= (gap == 0) ? 3 + $urandom % 4 : gap - 1;
    BAUD_TICK <= gap == 0;
  end
  // Watchdog for a hung run
  initial begin
    repeat (60000) @(posedge CLOCK);
    err_count++;
    wrap_up();
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One Avalon access; held until waitrequest is low at a rising edge
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge CLOCK);
    ADDRESS <= a;
    WRITEDATA <= {24'h0, v};
    READ <= !wr;
    WRITE <= wr;
    // Read right after the edge, before the design's updates land: the sampled values
    do begin
      @(posedge CLOCK);
      n++;
    end while (WAITREQUEST !== 1'b0 && n < 50);
    q = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
    if (WAITREQUEST !== 1'b0 && n >= 50) begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    got = 1'b0;
    while (n < lim && !got) begin
      @(negedge CLOCK);
      got = TRANSFER_DONE_IRQ === 1'b1;
      n++;
    end
  endtask
  task automatic ext_pulses(input int k);
    repeat (k) begin
      @(posedge CLOCK) ext_sck <= 1'b0;
      repeat (10) @(posedge CLOCK);
      ext_sck <= 1'b1;
      repeat (9) @(posedge CLOCK);
    end
  endtask
  // The external clock is made here, so its frame is waited for alongside
  task automatic run(input logic [1:0] cs);
    if (cs == CLOCK_EXTERNAL)
      fork ext_pulses(8); wait_irq(400); join
    else
      wait_irq(600);
  endtask
  function automatic logic [7:0] ord(input logic [7:0] v, input logic lsb);
    for (int i = 0; i < 8; i++) ord[i] = lsb ? v[7 - i] : v[i];
  endfunction
  // Bus mode listens to its own wired line; line A floats when line B is chosen
  function automatic logic [7:0] peer_exp(input logic [7:0] md, v);
    return md[3] ? (md[4] ? 8'hFF : v) : ord(v, md[2]);
  endfunction
  function automatic logic [31:0] shift_exp(input logic [7:0] md, v, w);
    return !md[6] ? 32'h0 : {24'h0, md[3] ? v : ord(w, md[2])};
  endfunction
  // One frame started by a shift register write, checked both ways
  task automatic frame(input logic [7:0] md);
    p <= 8'($urandom);
    d = 8'($urandom);
    bus(1'b1, MODE_OFFSET, md);
    if (md[1:0] == CLOCK_EXTERNAL) begin
      got = DATA_A_OUT;
      ext_pulses(8);
      check("idle clock", DATA_A_OUT, got);
    end
    bus(1'b1, SHIFT_OFFSET, d);
    run(md[1:0]);
    check("irq", got, 1'b1);
    check("peer rx", peer_rx, peer_exp(md, d));
    bus(1'b0, SHIFT_OFFSET, 8'h00);
    check("shift rx", q, shift_exp(md, d, p));
    if (md[6]) begin
      run(md[1:0]);
      check("read start", got, 1'b1);
    end
  endtask
  initial begin
    void'($urandom(32'h0B11CF4F));
    repeat (6) @(posedge CLOCK);
    RESETN <= 1'b1;
    bus(1'b0, MODE_OFFSET, 8'h00);
    check("mode reset", q, 32'h0);
    d = 8'($urandom) & 8'hFC | 8'h20;
    bus(1'b1, MODE_OFFSET, d);
    BYTEENABLE <= 4'h0;
    bus(1'b1, MODE_OFFSET, 8'h00);
    BYTEENABLE <= 4'hF;
    bus(1'b0, 16'hFF90, 8'h00);
    check("unmapped", q, 32'h0);
    bus(1'b0, MODE_OFFSET, 8'h00);
    check("mode readback", q, {24'h0, d});
    bus(1'b1, MODE_OFFSET, 8'h00);
    for (int cs = 0; cs < 4; cs++) for (int l = 0; l < 2; l++) frame(8'(8'hC0 | l << 2 | l << 4 | cs));
    frame(8'h83);
    pulled <= 1'b1;
    frame(8'hCB);
    frame(8'hDB);
    pulled <= 1'b0;
    bus(1'b1, MODE_OFFSET, 8'h00);
    p <= 8'($urandom);
    bus(1'b1, MODE_OFFSET, 8'h43);
    run(CLOCK_FAST);
    check("rx start", got, 1'b1);
    check("tx floats", DATA_A_OE_N, 1'b1);
    bus(1'b1, MODE_OFFSET, 8'h43);
    wait_irq(100);
    check("no restart", got, 1'b0);
    bus(1'b0, SHIFT_OFFSET, 8'h00);
    check("rx only", q, {24'h0, p});
    run(CLOCK_FAST);
    bus(1'b1, MODE_OFFSET, 8'h00);
    bus(1'b1, MODE_OFFSET, 8'hC3);
    wait_irq(100);
    check("no start with tx", got, 1'b0);
    bus(1'b1, SHIFT_OFFSET, 8'h5A);
    repeat (8) @(posedge CLOCK);
    bus(1'b1, MODE_OFFSET, 8'h00);
    d = 8'($urandom);
    bus(1'b1, MODE_OFFSET, 8'h83);
    bus(1'b1, SHIFT_OFFSET, d);
    run(CLOCK_FAST);
    check("after abort", peer_rx, d);
    wrap_up();
  end
endmodule // clocked_serial_three_wire_port_bench
